// ==== logic/dci_pkg.sv ====
// constants and register map of the dsp cpu interrupt controller
// Notes on behaviour
// - a one written to clear strobe bits 4..15 clears that pending flag, zeros do nothing.
// - software can read the pending flags, one bit per cpu interrupt.
// - the enable register holds one enable bit for each cpu interrupt 0..15.
// - with the global enable clear no maskable interrupt is taken at all.
// - an interrupt is taken only if the global enable and its own enable are both set.
// - polarity bits 0..3 invert the active sense of external interrupts 4..7.
// - low and high mux registers (select 0 and 1) hold readable per-interrupt source fields.
// - each mux field holds a source number 0..15 that drives its cpu interrupt flag.
// - writing one to the host interrupt bit raises a request toward the host.
// - the idle stall lasts until an interrupt is serviced.
// - a writable service table pointer gives the base of the vector table.
// - a one written to set strobe bits 4..15 sets that pending flag.
// - writing one to the host-to-core interrupt bit clears that flag.
package dci_pkg;
  localparam int           DCI_NUM_INT   = 16;
  localparam int           DCI_FIRST_MSK = 4;
  localparam int           DCI_SEL_W     = 4;
  localparam int           DCI_NUM_PIN   = 4;
  localparam int           DCI_PIN_BASE  = 4;
  localparam int           DCI_LOW_FIRST = 4;
  localparam int           DCI_HIGH_FIRST = 12;
  localparam int           DCI_ADDR_W    = 6;
  // byte offsets of the register words
  localparam logic [5:0]   OFS_FLAG      = 6'h00;
  localparam logic [5:0]   OFS_SET       = 6'h04;
  localparam logic [5:0]   OFS_CLR       = 6'h08;
  localparam logic [5:0]   OFS_ENABLE    = 6'h0c;
  localparam logic [5:0]   OFS_CTRL      = 6'h10;
  localparam logic [5:0]   OFS_POLARITY  = 6'h14;
  localparam logic [5:0]   OFS_MUX_LOW   = 6'h18;
  localparam logic [5:0]   OFS_MUX_HIGH  = 6'h1c;
  localparam logic [5:0]   OFS_TABLE     = 6'h20;
  localparam logic [5:0]   OFS_HOST      = 6'h24;
  localparam logic [5:0]   OFS_EVT_STAT  = 6'h28;
  localparam logic [5:0]   OFS_EVT_MASK  = 6'h2c;
  // field positions
  localparam int           CTRL_GIE_BIT  = 0;
  localparam int           CTRL_IDLE_BIT = 1;
  localparam int           HOST_CORE_BIT = 0;
  localparam int           HOST_INT_BIT  = 1;
  localparam int           EVT_TAKEN     = 0;
  localparam int           EVT_HOST_CORE = 1;
  localparam int           EVT_IDLE_END  = 2;
  localparam int           EVT_W         = 3;
  localparam int           VEC_SHIFT     = 5;
  // writable part of the flag strobes: interrupts 4..15
  localparam logic [15:0]  MASKABLE      = 16'hfff0;
  // reset values
  localparam logic [31:0]  RST_MUX_LOW   = 32'hba987654;
  localparam logic [31:0]  RST_MUX_HIGH  = 32'h0000fedc;
  localparam logic [31:0]  RST_TABLE     = 32'h00000000;
  localparam logic [15:0]  RST_ENABLE    = 16'h0000;
endpackage

// ==== logic/dci_pin_edge.sv ====
// active-edge detector for the external interrupt pins
`timescale 1ns/1ns
module dci_pin_edge
  import dci_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic [DCI_NUM_PIN-1:0] pin,
  input  wire logic [DCI_NUM_PIN-1:0] invert,
  output logic      [DCI_NUM_PIN-1:0] evt
);
  logic [DCI_NUM_PIN-1:0] level;
  logic [DCI_NUM_PIN-1:0] prev_reg;

  genvar i;
  generate
    for (i = 0; i < DCI_NUM_PIN; i++) begin : g_pin
      // inverted sense turns a falling pin into a rising event
      assign level[i] = pin[i] ^ invert[i];
      assign evt[i]   = level[i] & ~prev_reg[i];
      // previous sensed level
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_reg[i] <= 1'b0;
        end else begin
          prev_reg[i] <= level[i];
        end
      end
    end
  endgenerate
endmodule

// ==== logic/dci_prio.sv ====
// lowest-number-first priority pick over the cpu interrupts
`timescale 1ns/1ns
module dci_prio
  import dci_pkg::*;
(
  input  wire logic [DCI_NUM_INT-1:0] req,
  output logic                        found,
  output logic      [3:0]             idx
);
  // scan from the top so the lowest set bit wins
  always_comb begin
    found = 1'b0;
    idx   = 4'h0;
    for (int i = DCI_NUM_INT - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = 4'(i);
      end
    end
  end
endmodule

// ==== logic/dci_ctrl.sv ====
// top of the dsp cpu interrupt controller with its avalon register slave
`timescale 1ns/1ns
module dci_ctrl
  import dci_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // avalon-mm slave
  input  wire logic [DCI_ADDR_W-1:0]  avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // interrupt sources
  input  wire logic [DCI_NUM_INT-1:0] periph_evt,
  input  wire logic [DCI_NUM_PIN-1:0] ext_int_pin,
  // cpu core side
  output logic                        cpu_int_req,
  output logic      [3:0]             cpu_int_num,
  output logic      [31:0]            cpu_vector_addr,
  input  wire logic                   cpu_int_ack,
  input  wire logic                   cpu_idle,
  output logic                        cpu_stall,
  // host port side
  output logic                        host_int_flag,
  input  wire logic                   host_int_clear,
  input  wire logic                   host_core_int_set,
  // interrupt toward software
  output logic                        irq
);
  // register state
  logic [DCI_NUM_INT-1:0] pending_flag_reg;
  logic [DCI_NUM_INT-1:0] pending_flag_next;
  logic [DCI_NUM_INT-1:0] per_int_enable_reg;
  logic                   global_int_enable_reg;
  logic [DCI_NUM_PIN-1:0] ext_polarity_reg;
  logic [31:0]            mux_low_reg;
  logic [31:0]            mux_high_reg;
  logic [31:0]            service_table_pointer_reg;
  logic                   host_to_core_int_flag_reg;
  logic                   host_int_flag_reg;
  logic [EVT_W-1:0]       evt_stat_reg;
  logic [EVT_W-1:0]       evt_stat_next;
  logic [EVT_W-1:0]       evt_mask_reg;
  logic                   irq_reg;

  // bus handshake state
  logic                   wait_reg;
  logic [31:0]            rdata_reg;
  logic                   bus_req;
  logic                   bus_acc;
  logic                   wr_acc;
  logic                   rd_acc;
  logic [31:0]            rd_mux;

  // dispatch state
  logic                   take_req_reg;
  logic [3:0]             take_num_reg;
  logic [31:0]            vector_reg;
  logic                   stall_reg;
  logic                   serviced;

  // source and flag helpers
  logic [DCI_NUM_PIN-1:0] pin_evt;
  logic [DCI_NUM_INT-1:0] src_all;
  logic [DCI_NUM_INT-1:0] mapped_evt;
  logic [DCI_NUM_INT-1:0] set_mask;
  logic [DCI_NUM_INT-1:0] clr_mask;
  logic [DCI_NUM_INT-1:0] ack_mask;
  logic [DCI_NUM_INT-1:0] eligible;
  logic                   cand_found;
  logic [3:0]             cand_idx;
  logic [EVT_W-1:0]       evt_set;

  // ------------------------------------------------------------------
  // avalon slave: one wait cycle, then the access completes
  // ------------------------------------------------------------------
  assign bus_req = avs_read | avs_write;
  assign bus_acc = bus_req & ~wait_reg;
  assign wr_acc  = bus_acc & avs_write;
  assign rd_acc  = bus_acc & avs_read;

  // waitrequest drops for exactly the completing cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
    end else if (bus_req && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // read data word for the addressed register
  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address)
      OFS_FLAG:     rd_mux[DCI_NUM_INT-1:0] = pending_flag_reg;
      OFS_ENABLE:   rd_mux[DCI_NUM_INT-1:0] = per_int_enable_reg;
      OFS_CTRL: begin
        rd_mux[CTRL_GIE_BIT]  = global_int_enable_reg;
        rd_mux[CTRL_IDLE_BIT] = stall_reg;
      end
      OFS_POLARITY: rd_mux[DCI_NUM_PIN-1:0] = ext_polarity_reg;
      OFS_MUX_LOW:  rd_mux = mux_low_reg;
      OFS_MUX_HIGH: rd_mux = mux_high_reg;
      OFS_TABLE:    rd_mux = service_table_pointer_reg;
      OFS_HOST: begin
        rd_mux[HOST_CORE_BIT] = host_to_core_int_flag_reg;
        rd_mux[HOST_INT_BIT]  = host_int_flag_reg;
      end
      OFS_EVT_STAT: rd_mux[EVT_W-1:0] = evt_stat_reg;
      OFS_EVT_MASK: rd_mux[EVT_W-1:0] = evt_mask_reg;
      default:      rd_mux = 32'h0;
    endcase
  end

  // read data captured in the wait cycle, stands at completion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0;
    end else if (bus_req && wait_reg && avs_read) begin
      rdata_reg <= rd_mux;
    end
  end

  // ------------------------------------------------------------------
  // sources: pins through polarity, then per-interrupt mux
  // ------------------------------------------------------------------
  dci_pin_edge u_pin_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (ext_int_pin),
    .invert  (ext_polarity_reg),
    .evt     (pin_evt)
  );

  // pin events take the source numbers of the external interrupts
  always_comb begin
    src_all = periph_evt;
    src_all[DCI_PIN_BASE +: DCI_NUM_PIN] = pin_evt;
  end

  genvar gi;
  generate
    for (gi = 0; gi < DCI_NUM_INT; gi++) begin : g_map
      if (gi < DCI_FIRST_MSK) begin : g_fixed
        // reset, nmi and reserved positions have no source
        assign mapped_evt[gi] = 1'b0;
      end else if (gi < DCI_HIGH_FIRST) begin : g_low
        // field of the low mux register
        assign mapped_evt[gi] =
          src_all[mux_low_reg[(gi - DCI_LOW_FIRST) * DCI_SEL_W +: DCI_SEL_W]];
      end else begin : g_high
        // field of the high mux register
        assign mapped_evt[gi] =
          src_all[mux_high_reg[(gi - DCI_HIGH_FIRST) * DCI_SEL_W +: DCI_SEL_W]];
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // pending flags
  // ------------------------------------------------------------------
  assign serviced = take_req_reg & cpu_int_ack;

  // set and clear masks from strobes, sources and acknowledge
  always_comb begin
    set_mask = mapped_evt;
    clr_mask = '0;
    ack_mask = '0;
    if (wr_acc && avs_address == OFS_SET) begin
      set_mask = set_mask | (avs_writedata[DCI_NUM_INT-1:0] & MASKABLE);
    end
    if (wr_acc && avs_address == OFS_CLR) begin
      clr_mask = avs_writedata[DCI_NUM_INT-1:0] & MASKABLE;
    end
    if (serviced) begin
      ack_mask[take_num_reg] = 1'b1;
    end
  end

  // an event in the clearing cycle survives the clear
  assign pending_flag_next = (pending_flag_reg & ~clr_mask & ~ack_mask) | set_mask;

  // the flag register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_flag_reg <= '0;
    end else begin
      pending_flag_reg <= pending_flag_next;
    end
  end

  // ------------------------------------------------------------------
  // software-written configuration
  // ------------------------------------------------------------------
  // per-interrupt enables
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_int_enable_reg <= RST_ENABLE;
    end else if (wr_acc && avs_address == OFS_ENABLE) begin
      per_int_enable_reg <= avs_writedata[DCI_NUM_INT-1:0];
    end
  end

  // global enable in the control word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_int_enable_reg <= 1'b0;
    end else if (wr_acc && avs_address == OFS_CTRL) begin
      global_int_enable_reg <= avs_writedata[CTRL_GIE_BIT];
    end
  end

  // external pin polarity
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_polarity_reg <= '0;
    end else if (wr_acc && avs_address == OFS_POLARITY) begin
      ext_polarity_reg <= avs_writedata[DCI_NUM_PIN-1:0];
    end
  end

  // source multiplexer registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_low_reg  <= RST_MUX_LOW;
      mux_high_reg <= RST_MUX_HIGH;
    end else if (wr_acc && avs_address == OFS_MUX_LOW) begin
      mux_low_reg  <= avs_writedata;
    end else if (wr_acc && avs_address == OFS_MUX_HIGH) begin
      mux_high_reg <= {16'h0, avs_writedata[15:0]};
    end
  end

  // vector table base
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      service_table_pointer_reg <= RST_TABLE;
    end else if (wr_acc && avs_address == OFS_TABLE) begin
      service_table_pointer_reg <= avs_writedata;
    end
  end

  // ------------------------------------------------------------------
  // host port flags
  // ------------------------------------------------------------------
  // host interrupt: set by software, cleared by the host
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_int_flag_reg <= 1'b0;
    end else if (wr_acc && avs_address == OFS_HOST && avs_writedata[HOST_INT_BIT]) begin
      host_int_flag_reg <= 1'b1;
    end else if (host_int_clear) begin
      host_int_flag_reg <= 1'b0;
    end
  end

  // host-to-core flag: set by the host, write one clears, set wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_to_core_int_flag_reg <= 1'b0;
    end else if (host_core_int_set) begin
      host_to_core_int_flag_reg <= 1'b1;
    end else if (wr_acc && avs_address == OFS_HOST && avs_writedata[HOST_CORE_BIT]) begin
      host_to_core_int_flag_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // dispatch toward the cpu
  // ------------------------------------------------------------------
  // only flags passing both enables compete
  always_comb begin
    eligible = '0;
    if (global_int_enable_reg) begin
      eligible = pending_flag_reg & per_int_enable_reg & MASKABLE;
    end
  end

  dci_prio u_prio (
    .req   (eligible),
    .found (cand_found),
    .idx   (cand_idx)
  );

  // request level follows the best candidate, drops for the cycle after the ack
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      take_req_reg <= 1'b0;
      take_num_reg <= 4'h0;
    end else begin
      take_req_reg <= cand_found & ~serviced;
      take_num_reg <= cand_idx;
    end
  end

  // vector address: table base plus a 32-byte slot per interrupt
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_reg <= 32'h0;
    end else begin
      vector_reg <= service_table_pointer_reg + (32'(cand_idx) << VEC_SHIFT);
    end
  end

  // idle stall: entered by the idle instruction, left on service
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_reg <= 1'b0;
    end else if (serviced) begin
      stall_reg <= 1'b0;
    end else if (cpu_idle) begin
      stall_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // software interrupt: sticky events, read clears, mask gates
  // ------------------------------------------------------------------
  always_comb begin
    evt_set = '0;
    evt_set[EVT_TAKEN]     = serviced;
    evt_set[EVT_HOST_CORE] = host_core_int_set;
    evt_set[EVT_IDLE_END]  = serviced & stall_reg;
  end

  // read clears only what it returned
  always_comb begin
    evt_stat_next = evt_stat_reg;
    if (rd_acc && avs_address == OFS_EVT_STAT) begin
      evt_stat_next = evt_stat_reg & ~rdata_reg[EVT_W-1:0];
    end
    evt_stat_next = evt_stat_next | evt_set;
  end

  // event status and mask registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_stat_reg <= '0;
      evt_mask_reg <= '0;
    end else begin
      evt_stat_reg <= evt_stat_next;
      if (wr_acc && avs_address == OFS_EVT_MASK) begin
        evt_mask_reg <= avs_writedata[EVT_W-1:0];
      end
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_stat_next & evt_mask_reg);
    end
  end

  // ------------------------------------------------------------------
  // outputs, all from flip-flops
  // ------------------------------------------------------------------
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign cpu_int_req     = take_req_reg;
  assign cpu_int_num     = take_num_reg;
  assign cpu_vector_addr = vector_reg;
  assign cpu_stall       = stall_reg;
  assign host_int_flag   = host_int_flag_reg;
  assign irq             = irq_reg;
endmodule

// ==== sim/dci_ctrl_props.sv ====
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ns
module dci_ctrl_props
  import dci_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic [DCI_ADDR_W-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  cpu_int_req,
  input wire logic                  cpu_int_ack,
  input wire logic                  cpu_idle,
  input wire logic                  cpu_stall,
  input wire logic                  host_int_flag,
  input wire logic                  host_int_clear
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // one wait cycle, then one low cycle
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest not low after one cycle");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  // read data contents
  property p_flag_low;
    avs_read && avs_address == OFS_FLAG && !avs_waitrequest |-> avs_readdata[3:0] == 4'h0;
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("flag bits 3..0 read nonzero");
  property p_mux_high;
    avs_read && avs_address == OFS_MUX_HIGH && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0;
  endproperty
  a_mux_high: assert property (p_mux_high) else $error("upper mux word bits nonzero");
  // acknowledge clears the request for a cycle
  property p_ack_drop;
    cpu_int_ack && cpu_int_req |=> !cpu_int_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
  // idle stall set, held and released
  property p_stall_rise;
    cpu_idle && !(cpu_int_ack && cpu_int_req) |=> cpu_stall;
  endproperty
  a_stall_rise: assert property (p_stall_rise) else $error("idle did not stall");
  property p_stall_hold;
    cpu_stall && !(cpu_int_ack && cpu_int_req) |=> cpu_stall;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall ended without service");
  property p_stall_end;
    cpu_stall && cpu_int_ack && cpu_int_req && !cpu_idle |=> !cpu_stall;
  endproperty
  a_stall_end: assert property (p_stall_end) else $error("stall kept after service");
  // host interrupt flag
  property p_host_clear;
    host_int_clear && !avs_write && !$past(avs_write) |=> !host_int_flag;
  endproperty
  a_host_clear: assert property (p_host_clear) else $error("host flag not cleared");
  property p_host_hold;
    host_int_flag && !host_int_clear |=> host_int_flag;
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("host flag dropped");

  c_ack: cover property (cpu_int_ack && cpu_int_req);
  c_idle: cover property (cpu_idle ##1 cpu_stall);
  c_host: cover property ($rose(host_int_flag));
endmodule

bind dci_ctrl dci_ctrl_props u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cpu_int_req(cpu_int_req), .cpu_int_ack(cpu_int_ack), .cpu_idle(cpu_idle),
  .cpu_stall(cpu_stall), .host_int_flag(host_int_flag), .host_int_clear(host_int_clear)
);

// ==== sim/dci_cpu_model.sv ====
// behavioural cpu core that takes dispatched interrupts
`timescale 1ns/1ns
module dci_cpu_model
  import dci_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       cpu_int_req,
  input  wire logic [3:0] cpu_int_num,
  input  wire logic       ack_on,
  input  wire logic [3:0] ack_wait,
  output logic            cpu_int_ack,
  output logic [3:0]      taken_num,
  output logic [7:0]      taken_cnt
);
  logic [3:0] wait_reg;

  // ack after a programmable delay, never two cycles running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_int_ack <= 1'b0;
      wait_reg    <= 4'h0;
    end else begin
      cpu_int_ack <= 1'b0;
      if (cpu_int_req && ack_on && !cpu_int_ack) begin
        if (wait_reg >= ack_wait) begin
          cpu_int_ack <= 1'b1;
          wait_reg    <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end

  // record what was really taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_num <= 4'h0;
      taken_cnt <= 8'h00;
    end else if (cpu_int_ack && cpu_int_req) begin
      taken_num <= cpu_int_num;
      taken_cnt <= taken_cnt + 8'h01;
    end
  end
endmodule

// ==== sim/dsp_cpu_interrupt_control_tb_top.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
module dsp_cpu_interrupt_control_tb_top
  import dci_pkg::*;
;
  logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, cpu_vector_addr, rd_val;
  logic [15:0] periph_evt;
  logic [3:0]  ext_int_pin, cpu_int_num, ack_wait, taken_num;
  logic        cpu_int_req, cpu_int_ack, cpu_idle, cpu_stall, irq, ack_on;
  logic        host_int_flag, host_int_clear, host_core_int_set;
  logic [7:0]  taken_cnt;
  int          num_errors, compares;

  dci_ctrl uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .periph_evt(periph_evt), .ext_int_pin(ext_int_pin),
    .cpu_int_req(cpu_int_req), .cpu_int_num(cpu_int_num), .cpu_vector_addr(cpu_vector_addr),
    .cpu_int_ack(cpu_int_ack), .cpu_idle(cpu_idle), .cpu_stall(cpu_stall),
    .host_int_flag(host_int_flag), .host_int_clear(host_int_clear),
    .host_core_int_set(host_core_int_set), .irq(irq));
  dci_cpu_model u_cpu (
    .ref_clk(ref_clk), .rst_n(rst_n), .cpu_int_req(cpu_int_req), .cpu_int_num(cpu_int_num),
    .ack_on(ack_on), .ack_wait(ack_wait), .cpu_int_ack(cpu_int_ack),
    .taken_num(taken_num), .taken_cnt(taken_cnt));

  // clock
  always #25 ref_clk = ~ref_clk;

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon access, held to waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) num_errors++;
    rd_val = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd_val, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one-cycle pulse: 0 idle, 1 host clear, 2 host-to-core set, else sources
  task automatic pulse(input int k, input logic [15:0] v);
    @(posedge ref_clk);
    if (k == 0) cpu_idle <= 1'b1;
    else if (k == 1) host_int_clear <= 1'b1;
    else if (k == 2) host_core_int_set <= 1'b1;
    else periph_evt <= v;
    @(posedge ref_clk);
    {cpu_idle, host_int_clear, host_core_int_set} <= 3'b000;
    periph_evt <= 16'h0;
  endtask
  // wait for a request, sampled mid-cycle
  task automatic wait_req;
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (cpu_int_req !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
  endtask

  task automatic report_and_stop;
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {avs_read, avs_write, cpu_idle, host_int_clear, host_core_int_set, ack_on} = 6'h0;
    avs_address = 6'h0;
    avs_writedata = 32'h0;
    periph_evt = 16'h0;
    ext_int_pin = 4'h0;
    ack_wait = 4'h3;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, strobe words skipped, 0x30 unmapped
    for (int i = 0; i < 13; i++) begin
      if (i != 1 && i != 2) rdc(6'(i * 4), i == 6 ? RST_MUX_LOW : i == 7 ? RST_MUX_HIGH : 32'h0);
    end
    // access kinds
    wr(OFS_ENABLE, 32'hffffffff);
    rdc(OFS_ENABLE, 32'h0000ffff);
    wr(OFS_MUX_HIGH, 32'hffffffff);
    rdc(OFS_MUX_HIGH, 32'h0000ffff);
    wr(OFS_MUX_HIGH, RST_MUX_HIGH);
    wr(OFS_TABLE, 32'h00001000);
    rdc(OFS_TABLE, 32'h00001000);
    wr(6'h30, 32'hffffffff);
    rdc(6'h30, 32'h0);
    wr(OFS_FLAG, 32'hffffffff);
    rdc(OFS_FLAG, 32'h0);
    // set and clear strobes
    wr(OFS_SET, 32'hffffffff);
    rdc(OFS_FLAG, 32'h0000fff0);
    wr(OFS_CLR, 32'h000000ff);
    rdc(OFS_FLAG, 32'h0000ff00);
    wr(OFS_CLR, 32'h0);
    rdc(OFS_FLAG, 32'h0000ff00);
    wr(OFS_CLR, 32'hffffffff);
    rdc(OFS_FLAG, 32'h0);
    // dispatch gating, vector and priority
    ack_on <= 1'b1;
    wr(OFS_SET, 32'h00000200);
    cyc(4);
    chk(32'(cpu_int_req), 32'h0);
    wr(OFS_ENABLE, 32'h0000fdff);
    wr(OFS_CTRL, 32'h1);
    cyc(4);
    chk(32'(cpu_int_req), 32'h0);
    wr(OFS_ENABLE, 32'h0000ffff);
    wait_req();
    chk(32'(cpu_int_num), 32'd9);
    chk(cpu_vector_addr, 32'h1000 + (32'd9 << VEC_SHIFT));
    cyc(8);
    chk(32'(taken_num), 32'd9);
    rdc(OFS_FLAG, 32'h0);
    wr(OFS_SET, 32'h00001020);
    cyc(20);
    chk(32'(taken_num), 32'd12);
    chk(32'(taken_cnt), 32'd3);
    chk(32'(irq), 32'h0);
    rdc(OFS_EVT_STAT, 32'h1);
    rdc(OFS_EVT_STAT, 32'h0);
    // source routing
    ack_on <= 1'b0;
    pulse(3, 16'h0400);
    rdc(OFS_FLAG, 32'h00000400);
    wr(OFS_CLR, 32'h00000400);
    wr(OFS_MUX_LOW, 32'h3a987654);
    pulse(3, 16'h0808);
    rdc(OFS_FLAG, 32'h00000800);
    wr(OFS_MUX_LOW, RST_MUX_LOW);
    wr(OFS_CLR, 32'hffffffff);
    // pin polarity
    @(posedge ref_clk);
    ext_int_pin <= 4'h1;
    rdc(OFS_FLAG, 32'h00000010);
    wr(OFS_CLR, 32'h00000010);
    wr(OFS_POLARITY, 32'hfffffff1);
    rdc(OFS_POLARITY, 32'h1);
    rdc(OFS_FLAG, 32'h0);
    @(posedge ref_clk);
    ext_int_pin <= 4'h0;
    rdc(OFS_FLAG, 32'h00000010);
    wr(OFS_CLR, 32'h00000010);
    // idle stall and interrupt output
    wr(OFS_EVT_MASK, 32'h7);
    pulse(0, 16'h0);
    cyc(3);
    chk(32'(cpu_stall), 32'h1);
    rdc(OFS_CTRL, 32'h3);
    ack_on <= 1'b1;
    wr(OFS_SET, 32'h00004000);
    cyc(12);
    chk(32'(cpu_stall), 32'h0);
    chk(32'(irq), 32'h1);
    rdc(OFS_EVT_STAT, 32'h5);
    cyc(2);
    chk(32'(irq), 32'h0);
    // host-to-core flag, unmasked event
    wr(OFS_EVT_MASK, 32'h2);
    pulse(2, 16'h0);
    cyc(2);
    chk(32'(irq), 32'h1);
    rdc(OFS_HOST, 32'h1);
    wr(OFS_HOST, 32'h1);
    rdc(OFS_HOST, 32'h0);
    rdc(OFS_EVT_STAT, 32'h2);
    cyc(2);
    chk(32'(irq), 32'h0);
    // host interrupt flag
    wr(OFS_HOST, 32'h2);
    cyc(2);
    chk(32'(host_int_flag), 32'h1);
    rdc(OFS_HOST, 32'h2);
    pulse(1, 16'h0);
    cyc(2);
    chk(32'(host_int_flag), 32'h0);
    report_and_stop();
  end
endmodule
